// ---- design/rcc_pkg.sv ----
// Package for the receive clock check block: offsets, fields, reset values
package rcc_pkg;

  // Register byte addresses (word aligned)
  localparam logic [7:0] RCC_CHECK_CTRL_OFS  = 8'h88;
  localparam logic [7:0] RCC_DMA_EVT_OFS     = 8'h8c;
  localparam logic [7:0] RCC_STATUS_OFS      = 8'h80;
  localparam logic [7:0] RCC_INT_MASK_OFS    = 8'h90;

  // Clock check control field positions
  localparam int RCC_CNT_LSB   = 24;
  localparam int RCC_MAX_LSB   = 16;
  localparam int RCC_MIN_LSB   = 8;
  localparam int RCC_PS_LSB    = 0;

  // Status and mask layout
  localparam int RCC_FAIL_BIT  = 2;
  localparam logic [31:0] RCC_STATUS_MASK = 32'h0000_0004;

  // Reset values
  localparam logic [7:0] RCC_CNT_RST  = 8'h00;
  localparam logic [7:0] RCC_MAX_RST  = 8'h00;
  localparam logic [7:0] RCC_MIN_RST  = 8'h00;
  localparam logic [3:0] RCC_PS_RST   = 4'h0;
  localparam logic       RCC_DMA_RST  = 1'b0;

  // Measurement window and prescaler limits
  localparam logic [4:0] RCC_WINDOW_LAST = 5'h1f;
  localparam logic [3:0] RCC_PS_MAX      = 4'h8;

  // Bus answers
  localparam logic [31:0] RCC_UNMAPPED_RD = 32'h0000_0000;

endpackage : rcc_pkg

// ---- design/rcc_edge_detect.sv ----
// Rising edge detector for the sampled receive master clock
`timescale 1ns/1ps
module rcc_edge_detect (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  // Sampled level and edge pulse
  input  wire logic level_in,
  output logic      rise_pulse
);
  import rcc_pkg::*;

  typedef struct packed {
    logic prev;
  } rcc_ed_state_t;

  rcc_ed_state_t st_reg;
  rcc_ed_state_t st_next;

  // Remember last level
  always_comb begin
    st_next      = st_reg;
    st_next.prev = level_in;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // One-cycle pulse on low to high
  assign rise_pulse = level_in & ~st_reg.prev;

endmodule : rcc_edge_detect

// ---- design/rcc_top.sv ----
// Receive clock failure checker with Avalon-MM register slave
// How it works
// - Prescaled system clocks are counted over every 32 master clock periods and the count is held as the result.
// - A count above the upper bound at window end sets the failure flag.
// - A count below the lower bound at window end sets the failure flag.
// - Both bounds are 8-bit and compared unsigned.
// - The prescaler divides by two to the code for codes 0 to 8; codes 9 to 15 are reserved.
// - Reserved bits read zero and ignore writes.
// - The DMA request enable bit means enabled at 0; 1 is reserved.
// - The failure flag sits at status bit 2, raises the interrupt when enabled, and clears on writing 1.
//
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/1ps
module rcc_top (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  // Avalon-MM slave
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Receive high-frequency master clock, sampled
  input  wire logic        rx_high_freq_master_clock,
  // Interrupt and DMA enable
  output logic             receive_interrupt,
  output logic             rx_dma_request_enable
);
  import rcc_pkg::*;

  typedef struct packed {
    logic        sync1;
    logic        sync2;
    logic [4:0]  period_cnt;
    logic [7:0]  prescale_cnt;
    logic [7:0]  check_cnt;
    logic        check_ovf;
    logic [7:0]  measured_clock_count;
    logic [7:0]  count_upper_bound;
    logic [7:0]  count_lower_bound;
    logic [3:0]  check_prescaler_select;
    logic        rx_dma_bit;
    logic        rx_clock_failure_flag;
    logic        fail_int_enable;
    logic        ack;
    logic [31:0] rdata;
  } rcc_state_t;

  rcc_state_t st_reg;
  rcc_state_t st_next;

  logic       mclk_rise;
  logic       ps_tick;
  logic       window_end;
  logic       count_fail;
  logic [7:0] ps_limit;
  logic [8:0] cnt_inc;
  logic       wr_go;
  logic       rd_go;

  // Master clock edge from the second synchroniser stage
  rcc_edge_detect u_edge (
    .sys_clk    (sys_clk),
    .sys_rst    (sys_rst),
    .level_in   (st_reg.sync2),
    .rise_pulse (mclk_rise)
  );

  // Prescaler terminal value; reserved codes clamp to divide by 256
  // prescale divider
  always_comb begin
    if (st_reg.check_prescaler_select >= RCC_PS_MAX) begin
      ps_limit = 8'hff;
    end else begin
      ps_limit = 8'((9'h001 << st_reg.check_prescaler_select) - 9'h001);
    end
  end

  assign ps_tick    = (st_reg.prescale_cnt == ps_limit);
  assign window_end = mclk_rise && (st_reg.period_cnt == RCC_WINDOW_LAST);
  assign cnt_inc    = {1'b0, st_reg.check_cnt} + 9'h001;

  assign count_fail = st_reg.check_ovf
                    || (st_reg.check_cnt > st_reg.count_upper_bound)
                    || (st_reg.check_cnt < st_reg.count_lower_bound);

  // Single-cycle answer: waitrequest low on first request cycle
  assign wr_go = avs_write && !avs_read;
  assign rd_go = avs_read && !avs_write;

  // Next state
  always_comb begin
    st_next       = st_reg;
    st_next.sync1 = rx_high_freq_master_clock;
    st_next.sync2 = st_reg.sync1;

    // Prescaler always runs
    st_next.prescale_cnt = ps_tick ? 8'h00 : 8'(st_reg.prescale_cnt + 8'h01);

    if (ps_tick && !window_end) begin
      if (cnt_inc[8]) begin
        st_next.check_ovf = 1'b1;
      end else begin
        st_next.check_cnt = cnt_inc[7:0];
      end
    end
    if (mclk_rise) begin
      st_next.period_cnt = 5'(st_reg.period_cnt + 5'h01);
    end
    if (window_end) begin
      st_next.measured_clock_count = st_reg.check_ovf ? 8'hff : st_reg.check_cnt;
      st_next.check_cnt    = 8'h00;
      st_next.check_ovf    = 1'b0;
      st_next.prescale_cnt = 8'h00;
    end

    // Register writes, byte lanes honoured
    if (wr_go) begin
      case (avs_address)
        RCC_CHECK_CTRL_OFS: begin
          if (avs_byteenable[0]) begin
            st_next.check_prescaler_select = avs_writedata[RCC_PS_LSB +: 4];
          end
          if (avs_byteenable[1]) begin
            st_next.count_lower_bound = avs_writedata[RCC_MIN_LSB +: 8];
          end
          if (avs_byteenable[2]) begin
            st_next.count_upper_bound = avs_writedata[RCC_MAX_LSB +: 8];
          end
        end
        RCC_DMA_EVT_OFS: begin
          if (avs_byteenable[0]) begin
            st_next.rx_dma_bit = avs_writedata[0];
          end
        end
        RCC_STATUS_OFS: begin
          if (avs_byteenable[0] && avs_writedata[RCC_FAIL_BIT]) begin
            st_next.rx_clock_failure_flag = 1'b0;
          end
        end
        RCC_INT_MASK_OFS: begin
          if (avs_byteenable[0]) begin
            st_next.fail_int_enable = avs_writedata[RCC_FAIL_BIT];
          end
        end
        default: begin
          st_next.ack = st_reg.ack;
        end
      endcase
    end

    if (window_end && count_fail) begin
      st_next.rx_clock_failure_flag = 1'b1;
    end

    // Read data registered on the accepting edge
    st_next.ack = 1'b0;
    if (rd_go) begin
      case (avs_address)
        RCC_CHECK_CTRL_OFS: begin
          st_next.rdata = {st_reg.measured_clock_count, st_reg.count_upper_bound,
                           st_reg.count_lower_bound, 4'h0, st_reg.check_prescaler_select};
        end
        RCC_DMA_EVT_OFS: begin
          st_next.rdata = {31'h0, st_reg.rx_dma_bit};
        end
        RCC_STATUS_OFS: begin
          st_next.rdata = {29'h0, st_reg.rx_clock_failure_flag, 2'h0};
        end
        RCC_INT_MASK_OFS: begin
          st_next.rdata = {29'h0, st_reg.fail_int_enable, 2'h0};
        end
        default: begin
          st_next.rdata = RCC_UNMAPPED_RD;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_reg                        <= '0;
      st_reg.measured_clock_count   <= RCC_CNT_RST;
      st_reg.count_upper_bound      <= RCC_MAX_RST;
      st_reg.count_lower_bound      <= RCC_MIN_RST;
      st_reg.check_prescaler_select <= RCC_PS_RST;
      st_reg.rx_dma_bit             <= RCC_DMA_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // Bus outputs: no wait states, read data combinational during a read, else held in flip-flops from the previous read
  assign avs_waitrequest = 1'b0;
  assign avs_readdata    = rd_go ? read_mux(avs_address) : st_reg.rdata;

  // Combinational read view so data stands at the accepting edge
  function automatic logic [31:0] read_mux(input logic [7:0] addr);
    logic [31:0] v;
    v = RCC_UNMAPPED_RD;
    case (addr)
      RCC_CHECK_CTRL_OFS: v = {st_reg.measured_clock_count, st_reg.count_upper_bound,
                               st_reg.count_lower_bound, 4'h0, st_reg.check_prescaler_select};
      RCC_DMA_EVT_OFS:    v = {31'h0, st_reg.rx_dma_bit};
      RCC_STATUS_OFS:     v = {29'h0, st_reg.rx_clock_failure_flag, 2'h0};
      RCC_INT_MASK_OFS:   v = {29'h0, st_reg.fail_int_enable, 2'h0};
      default:            v = RCC_UNMAPPED_RD;
    endcase
    return v;
  endfunction : read_mux

  assign receive_interrupt = st_reg.rx_clock_failure_flag & st_reg.fail_int_enable;

  assign rx_dma_request_enable = ~st_reg.rx_dma_bit;

endmodule : rcc_top

// ---- testbench/rcc_monitor.sv ----
// Checker for the register and interrupt ports
`timescale 1ns/1ps
module rcc_monitor (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  // Register bus
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // Master clock input and outputs
  input wire logic        rx_high_freq_master_clock,
  input wire logic        receive_interrupt,
  input wire logic        rx_dma_request_enable
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // Register and interrupt relations
  chk_dma_write: assert property (avs_write && avs_address == 8'h8c && avs_byteenable[0] |=>
    rx_dma_request_enable == !$past(avs_writedata[0])) else $error("dma enable wrong");
  chk_dma_hold: assert property (!(avs_write && avs_address == 8'h8c) |=>
    $stable(rx_dma_request_enable)) else $error("dma enable moved");
  chk_dma_rsvd: assert property (avs_read && avs_address == 8'h8c |->
    avs_readdata[31:1] == 31'h0) else $error("dma reserved bits set");
  chk_ctrl_rsvd: assert property (avs_read && avs_address == 8'h88 |->
    avs_readdata[7:4] == 4'h0) else $error("ctrl reserved bits set");
  chk_ctrl_rw: assert property (avs_write && avs_address == 8'h88 && avs_byteenable == 4'hf
    ##1 !avs_write ##1 avs_read && avs_address == 8'h88 |-> avs_readdata[23:8] == $past(avs_writedata[23:8], 2))
    else $error("bounds readback wrong");
  chk_unmapped: assert property (avs_read && avs_address == 8'h84 |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  chk_irq_mask: assert property (avs_write && avs_address == 8'h90 && avs_byteenable[0] &&
    !avs_writedata[2] |=> !receive_interrupt) else $error("masked interrupt high");
  chk_irq_cause: assert property (avs_read && avs_address == 8'h80 && !avs_readdata[2]
    |-> !receive_interrupt) else $error("interrupt without flag");
endmodule : rcc_monitor

bind rcc_top rcc_monitor mon (.sys_clk(sys_clk), .sys_rst(sys_rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .rx_high_freq_master_clock(rx_high_freq_master_clock), .receive_interrupt(receive_interrupt),
  .rx_dma_request_enable(rx_dma_request_enable));

// ---- testbench/rcc_clk_src.sv ----
// Receive master clock source with a settable half period
`timescale 1ns/1ps
module rcc_clk_src (
  // Half period in ns, zero holds the clock low
  input wire logic [7:0] half_ns,
  output logic           clk_out
);
  // Free clock, phase offset from the system clock
  initial begin
    clk_out = 1'b0;
    #1.3;
    forever begin
      if (half_ns == 8'h0) begin
        clk_out = 1'b0;
        #1;
      end else begin
        #(half_ns) clk_out = ~clk_out;
      end
    end
  end
endmodule : rcc_clk_src

// ---- testbench/rcc_tb_top.sv ----
// Testbench for the receive clock check block
`timescale 1ns/1ps
module rcc_tb_top;
  import rcc_pkg::*;
  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  avs_address = 8'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [7:0]  half_ns = 8'h0;
  logic        mclk;
  logic        irq;
  logic        dma_en;
  logic [31:0] rv;
  int          fails = 0;
  int          checked = 0;
  // System clock
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  rcc_clk_src src (.half_ns(half_ns), .clk_out(mclk));
  rcc_top dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rx_high_freq_master_clock(mclk),
    .receive_interrupt(irq), .rx_dma_request_enable(dma_en));
  task automatic final_report;
    if (fails == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : final_report
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic chk_rng(input string n, input logic [7:0] lo, input logic [7:0] hi, input logic [7:0] g);
    checked++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      fails++;
      $display("unexpected %s expected %h to %h seen %h", n, lo, hi, g);
    end
  endtask : chk_rng
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    rv = avs_readdata;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask : rd
  // Program bounds, clear the flag after settling, then judge one clean span
  task automatic meas(input logic [31:0] ctl, input logic [31:0] sts);
    wr(RCC_CHECK_CTRL_OFS, ctl);
    rd(RCC_CHECK_CTRL_OFS);
    chk("ctrl", ctl & 32'h00ff_ff0f, rv & 32'h00ff_ffff);
    repeat (300) @(posedge sys_clk);
    wr(RCC_STATUS_OFS, 32'h4);
    repeat (300) @(posedge sys_clk);
    rd(RCC_STATUS_OFS);
    chk("status", sts, rv);
    chk("irq", {31'h0, sts[2]}, {31'h0, irq});
    rd(RCC_CHECK_CTRL_OFS);
  endtask : meas
  // Main sequence; master clock period is four system clocks
  initial begin
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    half_ns <= 8'd10;
    @(posedge sys_clk);
    rd(RCC_CHECK_CTRL_OFS);
    chk("ctrl reset", 32'h0, rv);
    chk("dma pin", 32'h1, {31'h0, dma_en});
    wr(RCC_DMA_EVT_OFS, 32'hffff_fffe);
    rd(RCC_DMA_EVT_OFS);
    chk("dma reg", 32'h0, rv);
    rd(8'h84);
    chk("unmapped", RCC_UNMAPPED_RD, rv);
    wr(RCC_INT_MASK_OFS, 32'h4);
    meas(32'h0090_10f0, 32'h0);
    chk_rng("count", 8'h7e, 8'h82, rv[31:24]);
    meas(32'h0060_1000, 32'h4);
    wr(RCC_INT_MASK_OFS, 32'h0);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(RCC_INT_MASK_OFS, 32'h4);
    meas(32'h00ff_a000, 32'h4);
    meas(32'h0030_1002, 32'h0);
    chk_rng("count ps2", 8'h1e, 8'h22, rv[31:24]);
    final_report();
  end
  // Watchdog
  initial begin
    repeat (5000) @(posedge sys_clk);
    fails++;
    final_report();
  end
endmodule : rcc_tb_top
